// file: rtl/cpu_fetch_pc_pipeline.sv
`timescale 1ns/1ps

// How it works
// - 21-bit counter, low byte readable and writable
// - middle byte only loaded through high latch
// - upper byte only loaded through upper latch
// - bit zero fixed, sequential step two
// - jumps and branches load counter directly
// - low byte write pulls in both latches
// - low byte read refreshes both latches
// - input clock divided into four phases
// - advance in phase one, latch in four
// - fetch overlaps execute, one per cycle
// - counter change flushes next fetched word
// - operand read phase two, write four
// - absolute word address into bits 20:1
// - relative offset counts two-byte words
// - second word tagged, twelve data bits used
// - orphan second word runs as no-op
// - add to low byte keeps latches
// - data addresses are twelve bits
// - bank select low nibble picks bank
// - unimplemented data reads return zero
// - pointers hold full twelve-bit address
// - access region ignores bank select
// - fetch starts at zero after reset

`include "cpu_fetch_map.svh"

module cpu_fetch_pc_pipeline
    import cpu_fetch_pkg::*;
#(
    parameter int PC_W = 21,
    parameter int DA_W = 12,
    parameter int NUM_PTR = 3
)(
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // program memory
    output logic [PC_W-1:0] o_prog_addr,
    input wire logic [15:0] i_prog_data,
    // decoded control for the word in execute
    input wire exec_ctl_t i_ctl,
    // instruction to the decoder
    output logic [15:0] o_instr,
    output logic o_instr_valid,
    output logic [11:0] o_second_data,
    output logic o_second_valid,
    output phase_t o_phase,
    // data memory
    output dm_req_t o_dm,
    input wire logic [7:0] i_dm_rdata,
    input wire logic i_dm_impl,
    output logic [7:0] o_operand
);

    // ****************************************
    // elaboration checks
    // ****************************************
    generate
        if (PC_W != 21 || DA_W != 12 || NUM_PTR < 1 || NUM_PTR > 3)
        begin : g_bad_param
            $error("cpu_fetch_pc_pipeline: unsupported parameter values");
        end
    endgenerate

    // ****************************************
    // state
    // ****************************************
    logic [20:0] pc_r;
    logic [20:0] fetch_r;
    logic [15:0] ir_r;
    logic ir_valid_r;
    logic pair_r;
    logic [7:0] lath_r;
    logic [4:0] latu_r;
    logic [3:0] bsr_r;
    logic [11:0] dm_addr_r;
    logic dm_rd_r;
    logic dm_wr_r;
    logic [7:0] wdata_r;
    logic [7:0] operand_r;
    logic [11:0] ptr_r [NUM_PTR];
    phase_t phase;

    // ****************************************
    // phase generator
    // ****************************************
    // four phases per cycle
    cpu_phase_gen u_phase
    (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_clk_en(i_clk_en),
        .o_phase(phase)
    );

    wire ph1 = i_clk_en & (phase == PH_ONE);
    wire ph2 = i_clk_en & (phase == PH_TWO);
    wire ph3 = i_clk_en & (phase == PH_THREE);
    wire ph4 = i_clk_en & (phase == PH_FOUR);

    // ****************************************
    // execute qualification
    // ****************************************
    // orphan second word is a no-op
    wire orphan = (ir_r[15:12] == `SECOND_WORD_TAG) & ~pair_r;
    wire exec_ok = ir_valid_r & ~orphan;
    wire pc_op_t op_v = exec_ok ? i_ctl.op : OP_NONE;

    // ****************************************
    // direct and indirect data address
    // ****************************************
    // access region, bank 0 low or bank 15 high
    wire [3:0] acc_bank = (i_ctl.dm_file < `ACCESS_SPLIT) ? `BANK_LOW : `BANK_HIGH;
    // bank from low nibble of bank select
    wire [3:0] use_bank = i_ctl.dm_acc ? acc_bank : bsr_r;
    wire [11:0] dir_addr = {use_bank, i_ctl.dm_file};

    wire [11:0] eff_chain [NUM_PTR+1];
    wire own_chain [NUM_PTR+1];
    wire [7:0] own_val_chain [NUM_PTR+1];
    wire [NUM_PTR-1:0] ptr_lo_wr;
    wire [NUM_PTR-1:0] ptr_hi_wr;

    wire own_fixed = (dm_addr_r == `ADDR_PCL) | (dm_addr_r == `ADDR_LATH) |
                     (dm_addr_r == `ADDR_LATU) | (dm_addr_r == `ADDR_BSR);
    wire [7:0] own_fixed_val = (dm_addr_r == `ADDR_PCL) ? fetch_r[7:0] :
                               (dm_addr_r == `ADDR_LATH) ? lath_r :
                               (dm_addr_r == `ADDR_LATU) ? {3'b000, latu_r} :
                               (dm_addr_r == `ADDR_BSR) ? {4'h0, bsr_r} : `RST_BYTE;

    assign eff_chain[0] = dir_addr;
    assign own_chain[0] = own_fixed;
    assign own_val_chain[0] = own_fixed_val;

    // ****************************************
    // indirect pointers
    // ****************************************
    genvar n;
    generate
        for (n = 0; n < NUM_PTR; n++)
        begin : g_ptr
            localparam logic [11:0] LO_A = `ADDR_PTR0_LO - (`PTR_STRIDE * 12'(n));
            localparam logic [11:0] HI_A = LO_A + 12'h001;
            localparam logic [11:0] IND_A = `ADDR_IND0 - (`PTR_STRIDE * 12'(n));
            wire lo_hit = (dm_addr_r == LO_A);
            wire hi_hit = (dm_addr_r == HI_A);
            wire load_me = (op_v == OP_LOAD_PTR) & (i_ctl.ptr_sel == 2'(n));

            assign eff_chain[n+1] = (dir_addr == IND_A) ? ptr_r[n] : eff_chain[n];
            assign own_chain[n+1] = own_chain[n] | lo_hit | hi_hit;
            assign own_val_chain[n+1] = lo_hit ? ptr_r[n][7:0] :
                                        hi_hit ? {4'h0, ptr_r[n][11:8]} : own_val_chain[n];
            assign ptr_lo_wr[n] = dm_wr_r & lo_hit;
            assign ptr_hi_wr[n] = dm_wr_r & hi_hit;

            always_ff @(posedge i_clk or posedge i_sys_rst)
            begin
                if (i_sys_rst)
                    ptr_r[n] <= `RST_PTR;
                else if (ph4 && load_me)
                    ptr_r[n] <= i_ctl.ptr_val;
                else if (ph4 && ptr_lo_wr[n])
                    ptr_r[n] <= {ptr_r[n][11:8], wdata_r};
                else if (ph4 && ptr_hi_wr[n])
                    ptr_r[n] <= {wdata_r[3:0], ptr_r[n][7:0]};
            end
        end
    endgenerate

    wire own_hit = own_chain[NUM_PTR];
    wire [7:0] own_val = own_val_chain[NUM_PTR];

    // ****************************************
    // counter targets
    // ****************************************
    // word address into bits 20:1
    wire [20:0] abs_tgt = {i_ctl.abs_word, 1'b0};
    wire [20:0] rel_tgt = fetch_r + {{9{i_ctl.rel_ofs[10]}}, i_ctl.rel_ofs, 1'b0};
    wire [20:0] add_sum = fetch_r + {13'h0000, i_ctl.working_register};
    wire [20:0] add_tgt = {add_sum[20:1], 1'b0};
    // low byte write takes both latches
    wire pcl_wr = dm_wr_r & (dm_addr_r == `ADDR_PCL);
    wire [20:0] pcl_tgt = {latu_r, lath_r, wdata_r[7:1], 1'b0};

    wire pc_load = (op_v == OP_ABS_JUMP) | (op_v == OP_REL_BRANCH) |
                   (op_v == OP_ADD_PCL) | pcl_wr;
    wire [20:0] pc_tgt = (op_v == OP_ABS_JUMP) ? abs_tgt :
                         (op_v == OP_REL_BRANCH) ? rel_tgt :
                         (op_v == OP_ADD_PCL) ? add_tgt : pcl_tgt;

    // ****************************************
    // program counter and fetch address
    // ****************************************
    // 21-bit counter
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            pc_r <= `PC_RESET;
        else if (ph1)
            pc_r <= pc_r + `PC_STEP;
        else if (ph4 && pc_load)
            pc_r <= {pc_tgt[20:1], 1'b0};
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            fetch_r <= `PC_RESET;
        else if (ph1)
            fetch_r <= pc_r;
    end

    // ****************************************
    // instruction register and flush
    // ****************************************
    // fetch of next overlaps execute
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            ir_r <= `RST_INSTR;
        else if (ph4)
            ir_r <= i_prog_data;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            ir_valid_r <= 1'b0;
            pair_r <= 1'b0;
        end
        else if (ph4)
        begin
            ir_valid_r <= ~(pc_load | (op_v == OP_SKIP));
            // first word arms use of second
            pair_r <= exec_ok & i_ctl.two_word & ~pc_load;
        end
    end

    // ****************************************
    // holding latches and bank select
    // ****************************************
    // cleared at reset
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            lath_r <= `RST_LATH;
            latu_r <= `RST_LATU;
        end
        else if (ph2 && dm_rd_r && dm_addr_r == `ADDR_PCL)
        begin
            lath_r <= fetch_r[15:8];
            latu_r <= fetch_r[20:16];
        end
        // middle byte reached via latch only
        else if (ph4 && dm_wr_r && dm_addr_r == `ADDR_LATH)
            lath_r <= wdata_r;
        // upper byte reached via latch only
        else if (ph4 && dm_wr_r && dm_addr_r == `ADDR_LATU)
            latu_r <= wdata_r[4:0];
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            bsr_r <= `RST_BSR;
        else if (ph4 && dm_wr_r && dm_addr_r == `ADDR_BSR)
            bsr_r <= wdata_r[3:0];
    end

    // ****************************************
    // data memory access
    // ****************************************
    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            dm_addr_r <= `RST_ADDR;
            dm_rd_r <= 1'b0;
            dm_wr_r <= 1'b0;
        end
        else if (ph1)
        begin
            dm_addr_r <= eff_chain[NUM_PTR];
            dm_rd_r <= exec_ok & i_ctl.dm_rd;
            dm_wr_r <= exec_ok & i_ctl.dm_wr;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            operand_r <= `RST_BYTE;
        else if (ph2 && dm_rd_r)
            operand_r <= own_hit ? own_val : (i_dm_impl ? i_dm_rdata : `RST_BYTE);
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            wdata_r <= `RST_BYTE;
        else if (ph3)
            wdata_r <= i_ctl.dm_wdata;
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_prog_addr = fetch_r;
    assign o_instr = ir_r;
    assign o_instr_valid = exec_ok;
    // twelve data bits of second word
    assign o_second_data = ir_r[11:0];
    assign o_second_valid = ir_valid_r & pair_r;
    assign o_phase = phase;
    assign o_operand = operand_r;

    // read strobe phase two, write phase four
    assign o_dm.addr = dm_addr_r;
    assign o_dm.rd = (phase == PH_TWO) & dm_rd_r & ~own_hit;
    assign o_dm.wr = (phase == PH_FOUR) & dm_wr_r & ~own_hit;
    assign o_dm.wdata = wdata_r;

endmodule : cpu_fetch_pc_pipeline

// file: rtl/cpu_fetch_map.svh
`ifndef CPU_FETCH_MAP_SVH
`define CPU_FETCH_MAP_SVH

// ****************************************
// program counter
// ****************************************
`define PC_RESET 21'h0_0000
`define PC_STEP 21'h0_0002

// ****************************************
// own special registers in data space
// ****************************************
`define ADDR_PCL 12'hFF9
`define ADDR_LATH 12'hFFA
`define ADDR_LATU 12'hFFB
`define ADDR_BSR 12'hFE0
`define ADDR_PTR0_LO 12'hFE9
`define ADDR_IND0 12'hFEF
`define PTR_STRIDE 12'h008

// ****************************************
// data addressing
// ****************************************
`define ACCESS_SPLIT 8'h80
`define BANK_LOW 4'h0
`define BANK_HIGH 4'hF
`define SECOND_WORD_TAG 4'hF

// ****************************************
// reset values
// ****************************************
`define RST_LATH 8'h00
`define RST_LATU 5'h00
`define RST_BSR 4'h0
`define RST_PTR 12'h000
`define RST_BYTE 8'h00
`define RST_ADDR 12'h000
`define RST_INSTR 16'h0000

`endif

// file: rtl/cpu_fetch_pkg.sv
package cpu_fetch_pkg;

    // ****************************************
    // phases of one instruction cycle
    // ****************************************
    typedef enum logic [1:0]
    {
        PH_ONE = 2'b00,
        PH_TWO = 2'b01,
        PH_THREE = 2'b10,
        PH_FOUR = 2'b11
    } phase_t;

    // ****************************************
    // counter changes, skip and pointer load asked by the executing instruction
    // ****************************************
    typedef enum logic [2:0]
    {
        OP_NONE = 3'b000,
        OP_ABS_JUMP = 3'b001,
        OP_REL_BRANCH = 3'b010,
        OP_ADD_PCL = 3'b011,
        OP_SKIP = 3'b100,
        OP_LOAD_PTR = 3'b101
    } pc_op_t;

    typedef struct packed {
        pc_op_t op;
        logic [19:0] abs_word;
        logic [10:0] rel_ofs;
        logic [7:0] working_register;
        logic two_word;
        logic [1:0] ptr_sel;
        logic [11:0] ptr_val;
        logic dm_rd;
        logic dm_wr;
        logic dm_acc;
        logic [7:0] dm_file;
        logic [7:0] dm_wdata;
    } exec_ctl_t;

    typedef struct packed {
        logic [11:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } dm_req_t;

endpackage : cpu_fetch_pkg

// file: rtl/cpu_phase_gen.sv
`timescale 1ns/1ps

module cpu_phase_gen
    import cpu_fetch_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // phase
    output phase_t o_phase
);

    phase_t ph_r;
    phase_t ph_nxt;

    // ****************************************
    // divide by four
    // ****************************************
    always_comb
    begin
        unique case (ph_r)
            PH_ONE: ph_nxt = PH_TWO;
            PH_TWO: ph_nxt = PH_THREE;
            PH_THREE: ph_nxt = PH_FOUR;
            PH_FOUR: ph_nxt = PH_ONE;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            ph_r <= PH_ONE;
        else if (i_clk_en)
            ph_r <= ph_nxt;
    end

    assign o_phase = ph_r;

endmodule : cpu_phase_gen

// file: dv/cpu_fetch_pc_pipeline_assertions.sv
`timescale 1ns/1ps

// ****
// port checker
// ****
module cpu_fetch_pc_pipeline_assertions
    import cpu_fetch_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    // watched ports
    input wire logic [20:0] o_prog_addr,
    input wire exec_ctl_t i_ctl,
    input wire logic [15:0] o_instr,
    input wire logic o_instr_valid,
    input wire logic [11:0] o_second_data,
    input wire logic o_second_valid,
    input wire phase_t o_phase,
    input wire dm_req_t o_dm,
    input wire logic [7:0] i_dm_rdata,
    input wire logic i_dm_impl,
    input wire logic [7:0] o_operand
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    wire logic ex4 = o_phase == PH_FOUR && i_clk_en && o_instr_valid;
    wire logic moves = i_ctl.op inside {OP_ABS_JUMP, OP_REL_BRANCH, OP_ADD_PCL};

    a_phase_step:
        assert property (i_clk_en |=> o_phase == $past(o_phase) + 2'h1)
        else $error("phase did not advance");
    a_read_slot:
        assert property (o_dm.rd |-> o_phase == PH_TWO)
        else $error("read strobe outside phase two");
    a_write_slot:
        assert property (o_dm.wr |-> o_phase == PH_FOUR)
        else $error("write strobe outside phase four");
    a_operand_take:
        assert property (o_dm.rd && i_clk_en |=> o_operand == ($past(i_dm_impl) ? $past(i_dm_rdata) : 8'h00))
        else $error("operand capture wrong");
    a_second_word:
        assert property (o_second_valid |-> o_instr[15:12] == 4'hF && o_second_data == o_instr[11:0])
        else $error("second word data wrong");
    a_step_two:
        assert property ((o_phase == PH_FOUR && i_clk_en && !(o_instr_valid && (moves || i_ctl.dm_wr)))
            ##1 i_clk_en |=> o_prog_addr == $past(o_prog_addr, 2) + 21'h0_0002)
        else $error("sequential fetch step wrong");
    a_flush_next:
        assert property (ex4 && (moves || i_ctl.op == OP_SKIP) |=> !o_instr_valid)
        else $error("next word not flushed");
    a_branch_rel:
        assert property ((ex4 && i_ctl.op == OP_REL_BRANCH) ##1 i_clk_en |=> o_prog_addr == $past(o_prog_addr, 2)
            + {{9{$past(i_ctl.rel_ofs[10], 2)}}, $past(i_ctl.rel_ofs, 2), 1'b0})
        else $error("relative target wrong");
    a_jump_abs:
        assert property ((ex4 && i_ctl.op == OP_ABS_JUMP) ##1 i_clk_en |=> o_prog_addr == {$past(i_ctl.abs_word, 2), 1'b0})
        else $error("absolute target wrong");
endmodule : cpu_fetch_pc_pipeline_assertions

// file: dv/cpu_mem_model.sv
`timescale 1ns/1ps

// ****
// program and data memory
// ****
module cpu_mem_model
    import cpu_fetch_pkg::*;
(
    // clock
    input wire logic i_clk,
    // program side
    input wire logic [20:0] i_prog_addr,
    output logic [15:0] o_prog_data,
    // data side
    input wire dm_req_t i_dm,
    output logic [7:0] o_dm_rdata,
    output logic o_dm_impl
);
    logic [15:0] prog [0:255];
    logic [7:0] ram [0:511];
    logic [7:0] junk_r = 8'hA5;

    assign o_dm_impl = i_dm.addr[11:9] == 3'h0;
    assign o_dm_rdata = o_dm_impl ? ram[i_dm.addr[8:0]] : junk_r;
    assign o_prog_data = prog[i_prog_addr[8:1]];

    always_ff @(posedge i_clk)
    begin
        junk_r <= junk_r + 8'h3B;
        if (i_dm.wr && o_dm_impl)
        begin
            ram[i_dm.addr[8:0]] <= i_dm.wdata;
        end
    end
endmodule : cpu_mem_model

// file: dv/cpu_fetch_pc_pipeline_test.sv
`timescale 1ns/1ps

module cpu_fetch_pc_pipeline_test
    import cpu_fetch_pkg::*;
();
    logic i_clk;
    logic i_sys_rst;
    logic i_clk_en;
    logic [20:0] o_prog_addr;
    logic [15:0] i_prog_data;
    exec_ctl_t i_ctl;
    logic [15:0] o_instr;
    logic o_instr_valid;
    logic [11:0] o_second_data;
    logic o_second_valid;
    phase_t o_phase;
    dm_req_t o_dm;
    logic [7:0] i_dm_rdata;
    logic i_dm_impl;
    logic [7:0] o_operand;
    exec_ctl_t ctl_tab [0:31];
    logic [15:0] log_i [$];
    logic [7:0] log_op [$];
    logic [19:0] log_wr [$];
    logic [11:0] log_sec [$];
    logic [15:0] exp_i [0:16] = '{16'h0001, 16'h0002, 16'h0004, 16'hF005, 16'h0006, 16'h0009, 16'h000A,
        16'h000B, 16'h000C, 16'h000D, 16'h000E, 16'h000F, 16'h0010, 16'h000E, 16'h0011, 16'h0012, 16'h0013};
    logic [7:0] exp_op [0:2] = '{8'h77, 8'h00, 8'h34};
    int fails = 0;
    int checks = 0;

    // decoder stand-in: control follows the executing word
    assign i_ctl = ctl_tab[o_instr[4:0]];

    cpu_fetch_pc_pipeline DUT (.i_clk, .i_sys_rst, .i_clk_en, .o_prog_addr, .i_prog_data, .i_ctl, .o_instr,
        .o_instr_valid, .o_second_data, .o_second_valid, .o_phase, .o_dm, .i_dm_rdata, .i_dm_impl, .o_operand);
    cpu_mem_model mdl (.i_clk, .i_prog_addr(o_prog_addr), .o_prog_data(i_prog_data), .i_dm(o_dm),
        .o_dm_rdata(i_dm_rdata), .o_dm_impl(i_dm_impl));

    // ****
    // helpers
    // ****
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic put(input logic [8:0] a, input logic [15:0] w, input pc_op_t op, input logic [11:0] v,
        input logic [3:0] f, input logic [7:0] fl, input logic [7:0] d);
        exec_ctl_t c;
        c = '0;
        c.op = op;
        c.abs_word = {8'h00, v};
        c.rel_ofs = v[10:0];
        c.working_register = v[7:0];
        c.ptr_val = v;
        {c.two_word, c.dm_rd, c.dm_wr, c.dm_acc} = f;
        c.dm_file = fl;
        c.dm_wdata = d;
        mdl.prog[a[8:1]] = w;
        ctl_tab[w[4:0]] = c;
    endtask : put

    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // ****
    // clock, monitor, watchdog
    // ****
    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // look mid-cycle, while the executing word still stands
    always @(negedge i_clk)
    begin
        if (i_clk_en === 1'b1 && o_phase === PH_FOUR)
        begin
            if (o_instr_valid === 1'b1)
            begin
                log_i.push_back(o_instr);
                if (i_ctl.dm_rd)
                begin
                    log_op.push_back(o_operand);
                end
            end
            if (o_second_valid === 1'b1)
            begin
                log_sec.push_back(o_second_data);
            end
            if (o_dm.wr === 1'b1)
            begin
                log_wr.push_back({o_dm.addr, o_dm.wdata});
            end
        end
    end

    initial
    begin
        #20000;
        fails++;
        close_out();
    end

    // ****
    // program and run
    // ****
    initial
    begin
        i_sys_rst = 1'b1;
        i_clk_en = 1'b0;
        for (int k = 0; k < 256; k++)
        begin
            mdl.prog[k] = 16'h0003;
            ctl_tab[k[4:0]] = '0;
        end
        put(9'h000, 16'h0001, OP_NONE, 12'h000, 4'h0, 8'h00, 8'h00);
        put(9'h002, 16'h0002, OP_REL_BRANCH, 12'h002, 4'h0, 8'h00, 8'h00);
        put(9'h008, 16'h0004, OP_NONE, 12'h000, 4'h8, 8'h00, 8'h00);
        put(9'h00A, 16'hF005, OP_ABS_JUMP, 12'h010, 4'h0, 8'h00, 8'h00);
        put(9'h020, 16'h0006, OP_SKIP, 12'h000, 4'h0, 8'h00, 8'h00);
        put(9'h022, 16'h0007, OP_NONE, 12'h000, 4'h8, 8'h00, 8'h00);
        put(9'h024, 16'hF008, OP_NONE, 12'h000, 4'h0, 8'h00, 8'h00);
        put(9'h026, 16'h0009, OP_NONE, 12'h000, 4'h3, 8'hE0, 8'h01);
        put(9'h028, 16'h000A, OP_NONE, 12'h000, 4'h2, 8'h34, 8'h77);
        put(9'h02A, 16'h000B, OP_NONE, 12'h000, 4'h4, 8'h34, 8'h00);
        put(9'h02C, 16'h000C, OP_LOAD_PTR, 12'h300, 4'h0, 8'h00, 8'h00);
        put(9'h02E, 16'h000D, OP_NONE, 12'h000, 4'h5, 8'hEF, 8'h00);
        put(9'h030, 16'h000E, OP_NONE, 12'h000, 4'h3, 8'hFA, 8'h01);
        put(9'h032, 16'h000F, OP_NONE, 12'h000, 4'h5, 8'hF9, 8'h00);
        put(9'h034, 16'h0010, OP_NONE, 12'h000, 4'h3, 8'hF9, 8'h40);
        put(9'h040, 16'h000E, OP_NONE, 12'h000, 4'h3, 8'hFA, 8'h01);
        put(9'h042, 16'h0011, OP_NONE, 12'h000, 4'h3, 8'hF9, 8'h50);
        put(9'h150, 16'h0012, OP_ADD_PCL, 12'h004, 4'h0, 8'h00, 8'h00);
        put(9'h156, 16'h0013, OP_REL_BRANCH, 12'h7FF, 4'h0, 8'h00, 8'h00);
        repeat (2) @(posedge i_clk);
        #1 i_sys_rst = 1'b0;
        i_clk_en = 1'b1;
        chk("fetch address", 32'h0000_0000, {11'h000, o_prog_addr});
        chk("phase", 32'h0000_0000, {30'h0000_0000, o_phase});
        chk("valid", 32'h0000_0000, {31'h0000_0000, o_instr_valid});
        // run with a one-cycle enable gap every fifth clock
        repeat (100)
        begin
            repeat (4) @(posedge i_clk);
            #1 i_clk_en = 1'b0;
            @(posedge i_clk);
            #1 i_clk_en = 1'b1;
        end
        chk("instr count", 32'h0000_0001, {31'h0000_0000, log_i.size() >= 17});
        for (int k = 0; k < 17; k++)
        begin
            chk("executed word", {16'h0000, exp_i[k]}, {16'h0000, log_i[k]});
        end
        chk("operand count", 32'h0000_0003, log_op.size());
        for (int k = 0; k < 3; k++)
        begin
            chk("operand", {24'h00_0000, exp_op[k]}, {24'h00_0000, log_op[k]});
        end
        chk("write count", 32'h0000_0001, log_wr.size());
        chk("write addr data", 32'h0001_3477, {12'h000, log_wr[0]});
        chk("second count", 32'h0000_0001, log_sec.size());
        chk("second data", 32'h0000_0005, {20'h0_0000, log_sec[0]});
        close_out();
    end
endmodule : cpu_fetch_pc_pipeline_test

bind cpu_fetch_pc_pipeline cpu_fetch_pc_pipeline_assertions u_chk (.i_clk, .i_sys_rst, .i_clk_en, .o_prog_addr,
    .i_ctl, .o_instr, .o_instr_valid, .o_second_data, .o_second_valid, .o_phase, .o_dm, .i_dm_rdata, .i_dm_impl,
    .o_operand);
